// >>> spc_cfg.svh
// Register map, field positions and timing counts of the synthesizer control sequencer
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_WORD_BITS 22
`define SPC_DATA_BITS 18
`define SPC_ADDR_MAIN 4'h0
`define SPC_ADDR_GAIN 4'h1
`define SPC_ADDR_PWR 4'h2
`define SPC_ADDR_N_RF1 4'h3
`define SPC_ADDR_N_RF2 4'h4
`define SPC_ADDR_N_IF 4'h5
`define SPC_ADDR_R_RF1 4'h6
`define SPC_ADDR_R_RF2 4'h7
`define SPC_ADDR_R_IF 4'h8
`define SPC_MAIN_AUTO_GAIN 2
`define SPC_MAIN_AUTO_PWR 3
`define SPC_MAIN_LOW_BIAS 5
`define SPC_MAIN_AUX_LO 12
`define SPC_PWR_RF_EN 0
`define SPC_PWR_IF_EN 1
`define SPC_R_BITS 13
`define SPC_TUNE_PERIODS 8'd13
`define SPC_SETTLE_PERIODS 8'd25
`define SPC_TOTAL_PERIODS 8'd40
`define SPC_AUX_LOW 2'h1
`define SPC_AUX_LOCK 2'h3
`endif

// >>> spc_host_model.sv
// Host model writing words over the three-wire serial link
`timescale 1ns/100ps
module spc_host_model (
   input wire logic clock,
   output logic serial_clock_pin,
   output logic serial_enable_n,
   output logic serial_data_pin
);
   initial begin
      serial_clock_pin = 1'b0;
      serial_enable_n = 1'b1;
      serial_data_pin = 1'b0;
   end
   // Link clock stands low outside frames
   task automatic send(input logic [3:0] addr, input logic [17:0] data);
      logic [21:0] w;
      w = {addr, data};
      serial_enable_n <= 1'b0;
      for (int i = 21; i >= 0; i--) begin
         serial_data_pin <= w[i];
         repeat (16) @(posedge clock);
         serial_clock_pin <= 1'b1;
         repeat (16) @(posedge clock);
         serial_clock_pin <= 1'b0;
      end
      repeat (16) @(posedge clock);
      serial_enable_n <= 1'b1;
      serial_data_pin <= ~w[0];
      repeat (16) @(posedge clock);
   endtask
endmodule // spc_host_model

// >>> spc_pkg.sv
// Types of the synthesizer control sequencer
package spc_pkg;
   typedef enum logic [1:0] {SPC_IDLE, SPC_TUNE, SPC_SETTLE, SPC_LOCKED} spc_state_t;
   typedef enum logic [1:0] {SPC_LOOP_RF1, SPC_LOOP_RF2, SPC_LOOP_IF} spc_loop_t;
endpackage

// >>> spc_synth_ctrl.sv
// Serial register file, loop sequencers, gain and power control of the synthesizer
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_synth_ctrl (
   input wire logic clock,
   input wire logic reset,
   input wire logic reference_input_pin,
   input wire logic serial_clock_pin,
   input wire logic serial_enable_n,
   input wire logic serial_data_pin,
   input wire logic chip_powerdown_n_pin,
   input wire logic rf_near_limit,
   input wire logic if_near_limit,
   output logic aux_output_pin,
   output logic lock_warn_n,
   output logic rf_section_on,
   output logic if_section_on,
   output logic ref_amp_on,
   output logic if_amp_low_bias,
   output logic [1:0] if_output_divide,
   output logic rf2_path_active,
   output logic [1:0] rf1_gain_code,
   output logic [1:0] rf2_gain_code,
   output logic [1:0] if_gain_code,
   output logic [2:0] loop_tuning,
   output logic [2:0] loop_settled,
   output logic [2:0] loop_compare
);
   import spc_pkg::*;

   // Two-flop synchronisers for pins
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic sclk_d_r;
   logic enable_n_d_r;
   // Enable bit resets high, so releasing reset gives no false commit
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync1_r <= 4'h2;
         sync2_r <= 4'h2;
      end else begin
         sync1_r <= {chip_powerdown_n_pin, reference_input_pin, serial_enable_n, serial_clock_pin};
         sync2_r <= sync1_r;
      end
   end
   wire logic sclk_s = sync2_r[0];
   wire logic enable_n_s = sync2_r[1];
   wire logic ref_s = sync2_r[2];
   wire logic pwdn_n_s = sync2_r[3];
   // Edge history of synchronised link strobes
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sclk_d_r <= 1'b0;
         enable_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         enable_n_d_r <= enable_n_s;
      end
   end
   logic sdata1_r;
   logic sdata2_r;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sdata1_r <= 1'b0;
         sdata2_r <= 1'b0;
      end else begin
         sdata1_r <= serial_data_pin;
         sdata2_r <= sdata1_r;
      end
   end

   // Serial shift register, independent of power state
   logic [`SPC_WORD_BITS-1:0] shift_r;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_r <= '0;
      end else if (!enable_n_s && sclk_s && !sclk_d_r) begin
         shift_r <= {shift_r[`SPC_WORD_BITS-2:0], sdata2_r};
      end
   end
   wire logic commit = enable_n_s && !enable_n_d_r;
   wire logic [3:0] waddr = shift_r[`SPC_WORD_BITS-1:`SPC_DATA_BITS];
   wire logic [`SPC_DATA_BITS-1:0] wdata = shift_r[`SPC_DATA_BITS-1:0];

   // Register file
   logic [`SPC_DATA_BITS-1:0] main_r;
   logic [5:0] gain_r;
   logic [1:0] pwr_r;
   logic [17:0] n_r [3];
   logic [`SPC_R_BITS-1:0] r_r [3];
   logic [2:0] dwrite;
   always_comb begin
      dwrite = 3'h0;
      if (commit) begin
         dwrite[0] = (waddr == `SPC_ADDR_N_RF1) || (waddr == `SPC_ADDR_R_RF1);
         dwrite[1] = (waddr == `SPC_ADDR_N_RF2) || (waddr == `SPC_ADDR_R_RF2);
         dwrite[2] = (waddr == `SPC_ADDR_N_IF) || (waddr == `SPC_ADDR_R_IF);
      end
   end
   // Main configuration word
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         main_r <= '0;
      end else if (commit && waddr == `SPC_ADDR_MAIN) begin
         main_r <= wdata;
      end
   end
   // Manual gain codes
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gain_r <= 6'h00;
      end else if (commit && waddr == `SPC_ADDR_GAIN) begin
         gain_r <= wdata[5:0];
      end
   end
   // Section enable bits
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pwr_r <= 2'h0;
      end else if (commit && waddr == `SPC_ADDR_PWR) begin
         pwr_r <= wdata[1:0];
      end
   end
   // Feedback dividers, one N value per loop, used only for automatic gain
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         n_r[0] <= '0;
         n_r[1] <= '0;
         n_r[2] <= '0;
      end else if (commit) begin
         case (waddr)
            `SPC_ADDR_N_RF1: n_r[0] <= wdata;
            `SPC_ADDR_N_RF2: n_r[1] <= {1'b0, wdata[16:0]};
            `SPC_ADDR_N_IF: n_r[2] <= {2'b00, wdata[15:0]};
            default: ;
         endcase
      end
   end
   // Reference dividers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r_r[0] <= '0;
         r_r[1] <= '0;
         r_r[2] <= '0;
      end else if (commit) begin
         case (waddr)
            `SPC_ADDR_R_RF1: r_r[0] <= wdata[`SPC_R_BITS-1:0];
            `SPC_ADDR_R_RF2: r_r[1] <= wdata[`SPC_R_BITS-1:0];
            `SPC_ADDR_R_IF: r_r[2] <= wdata[`SPC_R_BITS-1:0];
            default: ;
         endcase
      end
   end

   // Active RF path, last written wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rf2_path_active <= 1'b0;
      end else if (dwrite[0]) begin
         rf2_path_active <= 1'b0;
      end else if (dwrite[1]) begin
         rf2_path_active <= 1'b1;
      end
   end

   // Power decoding
   wire logic auto_power_on = main_r[`SPC_MAIN_AUTO_PWR];
   wire logic if_section_enable = pwr_r[`SPC_PWR_IF_EN];
   wire logic rf_section_enable = pwr_r[`SPC_PWR_RF_EN];
   logic rf_on;
   logic if_on;
   always_comb begin
      if (!pwdn_n_s) begin
         rf_on = 1'b0;
         if_on = 1'b0;
      end else if (auto_power_on) begin
         rf_on = 1'b1;
         if_on = 1'b1;
      end else begin
         rf_on = rf_section_enable;
         if_on = if_section_enable;
      end
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rf_section_on <= 1'b0;
         if_section_on <= 1'b0;
      end else begin
         rf_section_on <= rf_on;
         if_section_on <= if_on;
      end
   end
   // Reference amplifier follows either enable, auto power counting as both
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ref_amp_on <= 1'b0;
      end else begin
         ref_amp_on <= pwdn_n_s && (auto_power_on || rf_section_enable || if_section_enable);
      end
   end
   // IF output amplifier settings
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         if_amp_low_bias <= 1'b0;
         if_output_divide <= 2'h0;
      end else begin
         if_amp_low_bias <= main_r[`SPC_MAIN_LOW_BIAS];
         if_output_divide <= main_r[11:10];
      end
   end
   wire logic [2:0] loop_on = {if_on, rf_on && rf2_path_active, rf_on && !rf2_path_active};
   logic [2:0] loop_on_d_r;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         loop_on_d_r <= 3'h0;
      end else begin
         loop_on_d_r <= loop_on;
      end
   end

   // Reference edge detect feeds per-loop R counters
   logic ref_d_r;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ref_d_r <= 1'b0;
      end else begin
         ref_d_r <= ref_s;
      end
   end
   wire logic ref_rise = ref_s && !ref_d_r;

   // Per-loop reference divider and tune/settle sequencer
   spc_state_t st_r [3];
   logic [`SPC_R_BITS-1:0] rcnt_r [3];
   logic [7:0] pcnt_r [3];
   logic [2:0] tick;
   logic [2:0] start;
   for (genvar i = 0; i < 3; i++) begin : g_loop
      always_comb begin
         tick[i] = ref_rise && loop_on[i] && (rcnt_r[i] == '0);
         start[i] = (loop_on[i] && !loop_on_d_r[i]) || (loop_on[i] && dwrite[i]);
      end
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            rcnt_r[i] <= '0;
         end else if (!loop_on[i] || start[i]) begin
            rcnt_r[i] <= '0;
         end else if (ref_rise) begin
            if (rcnt_r[i] == '0) begin
               rcnt_r[i] <= (r_r[i] == '0) ? '0 : r_r[i] - `SPC_R_BITS'(1);
            end else begin
               rcnt_r[i] <= rcnt_r[i] - `SPC_R_BITS'(1);
            end
         end
      end
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            st_r[i] <= SPC_IDLE;
            pcnt_r[i] <= 8'h00;
         end else if (!loop_on[i]) begin
            st_r[i] <= SPC_IDLE;
            pcnt_r[i] <= 8'h00;
         end else if (start[i]) begin
            st_r[i] <= SPC_TUNE;
            pcnt_r[i] <= 8'h00;
         end else if (tick[i]) begin
            case (st_r[i])
               SPC_TUNE: begin
                  pcnt_r[i] <= pcnt_r[i] + 8'h01;
                  if (pcnt_r[i] == `SPC_TUNE_PERIODS - 8'h01) begin
                     st_r[i] <= SPC_SETTLE;
                  end
               end
               SPC_SETTLE: begin
                  pcnt_r[i] <= pcnt_r[i] + 8'h01;
                  if (pcnt_r[i] == `SPC_TUNE_PERIODS + `SPC_SETTLE_PERIODS - 8'h01) begin
                     st_r[i] <= SPC_LOCKED;
                  end
               end
               default: ;
            endcase
         end
      end
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            loop_tuning[i] <= 1'b0;
         end else begin
            loop_tuning[i] <= (st_r[i] == SPC_TUNE);
         end
      end
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            loop_settled[i] <= 1'b0;
         end else begin
            loop_settled[i] <= (st_r[i] == SPC_LOCKED);
         end
      end
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            loop_compare[i] <= 1'b0;
         end else begin
            loop_compare[i] <= tick[i];
         end
      end
   end

   // Automatic gain from N
   function automatic logic [1:0] gain_from_n(input logic [17:0] n, input logic [17:0] base);
      if (n >= (base << 3)) begin
         gain_from_n = 2'h3;
      end else if (n >= (base << 2)) begin
         gain_from_n = 2'h2;
      end else if (n >= (base << 1)) begin
         gain_from_n = 2'h1;
      end else begin
         gain_from_n = 2'h0;
      end
   endfunction
   wire logic auto_gain_select = main_r[`SPC_MAIN_AUTO_GAIN];
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rf1_gain_code <= 2'h0;
         rf2_gain_code <= 2'h0;
         if_gain_code <= 2'h0;
      end else if (auto_gain_select) begin
         rf1_gain_code <= gain_from_n(n_r[0], 18'h01000);
         rf2_gain_code <= gain_from_n(n_r[1], 18'h00800);
         if_gain_code <= gain_from_n(n_r[2], 18'h00400);
      end else begin
         rf1_gain_code <= gain_r[1:0];
         rf2_gain_code <= gain_r[3:2];
         if_gain_code <= gain_r[5:4];
      end
   end

   // Lock warning and aux output
   wire logic rf_tuning = rf2_path_active ? (st_r[1] == SPC_TUNE) : (st_r[0] == SPC_TUNE);
   wire logic any_tuning = rf_tuning || (st_r[2] == SPC_TUNE);
   wire logic near = (rf_on && rf_near_limit) || (if_on && if_near_limit);
   wire logic [1:0] aux_out_select = main_r[`SPC_MAIN_AUX_LO+1:`SPC_MAIN_AUX_LO];
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         lock_warn_n <= 1'b1;
      end else begin
         lock_warn_n <= any_tuning || near;
      end
   end
   // Aux output carries the lock warning on code 11, low otherwise
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         aux_output_pin <= 1'b0;
      end else if (aux_out_select == `SPC_AUX_LOCK) begin
         aux_output_pin <= any_tuning || near;
      end else begin
         aux_output_pin <= 1'b0;
      end
   end
endmodule // spc_synth_ctrl

// >>> spc_synth_ctrl_properties.sv
// Checker of the synthesizer control sequencer ports
`timescale 1ns/100ps
module spc_synth_ctrl_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic serial_enable_n,
   input wire logic chip_powerdown_n_pin,
   input wire logic rf_near_limit,
   input wire logic if_near_limit,
   input wire logic aux_output_pin,
   input wire logic lock_warn_n,
   input wire logic rf_section_on,
   input wire logic if_section_on,
   input wire logic ref_amp_on,
   input wire logic rf2_path_active,
   input wire logic [1:0] rf1_gain_code,
   input wire logic [2:0] loop_tuning,
   input wire logic [2:0] loop_compare
);
   logic sen_q, pin_q;
   logic [7:0] since_evt, tune_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Cycles since a commit or a power pin change
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sen_q <= 1'b1;
         pin_q <= 1'b0;
         since_evt <= 8'hFF;
      end else begin
         sen_q <= serial_enable_n;
         pin_q <= chip_powerdown_n_pin;
         if ((serial_enable_n && !sen_q) || chip_powerdown_n_pin != pin_q) begin
            since_evt <= 8'h00;
         end else if (since_evt != 8'hFF) begin
            since_evt <= since_evt + 8'h01;
         end
      end
   end
   // Update ticks seen during the current tuning of the IF loop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tune_cnt <= 8'h00;
      end else if (!loop_tuning[2] || (serial_enable_n && !sen_q)) begin
         tune_cnt <= 8'h00;
      end else if (loop_compare[2]) begin
         tune_cnt <= tune_cnt + 8'h01;
      end
   end
   warn_while_tune_a: assert property (|loop_tuning |-> lock_warn_n or ##1 lock_warn_n)
      else $error("lock warning low during tuning");
   pin_down_a: assert property (!chip_powerdown_n_pin [*4] |-> !rf_section_on && !if_section_on && !ref_amp_on)
      else $error("section on while power pin low");
   aux_lock_a: assert property (aux_output_pin |-> lock_warn_n || $past(lock_warn_n))
      else $error("aux output high without lock warning");
   limit_warn_a: assert property (if_near_limit && if_section_on |-> ##[0:2] lock_warn_n)
      else $error("no lock warning at limit");
   warn_clear_a: assert property ((loop_tuning == 3'h0 && !rf_near_limit && !if_near_limit) [*3] |-> !lock_warn_n)
      else $error("lock warning high with loops tuned");
   tune_len_a: assert property (tune_cnt <= 8'd13)
      else $error("tuning longer than its period count");
   tune_cause_a: assert property ($rose(|loop_tuning) |-> since_evt <= 8'd10)
      else $error("tuning started without cause");
   regs_stand_a: assert property ($changed(rf2_path_active) || $changed(rf1_gain_code) |-> since_evt <= 8'd10)
      else $error("register output changed without a write");
endmodule // spc_synth_ctrl_checker
bind spc_synth_ctrl spc_synth_ctrl_checker i_spc_synth_ctrl_checker (.*);

// >>> tb_spc_synth_ctrl.sv
// Self-checking bench of the synthesizer control sequencer
`timescale 1ns/100ps
`include "spc_cfg.svh"
module tb_spc_synth_ctrl;
   logic clock = 1'b0, reset = 1'b1, reference_input_pin = 1'b0;
   logic chip_powerdown_n_pin = 1'b0, rf_near_limit = 1'b0, if_near_limit = 1'b0;
   logic serial_clock_pin, serial_enable_n, serial_data_pin, sen_q, tun_q;
   logic aux_output_pin, lock_warn_n, rf_section_on, if_section_on, ref_amp_on, if_amp_low_bias, rf2_path_active;
   logic [1:0] if_output_divide, rf1_gain_code, rf2_gain_code, if_gain_code;
   logic [2:0] loop_tuning, loop_settled, loop_compare;
   logic [17:0] gap = 18'h0, last_gap = 18'h0, tune_ticks = 18'h0, all_ticks = 18'h0;
   int err_count = 0;
   int comparisons = 0;
   spc_host_model i_spc_host_model (.*);
   spc_synth_ctrl i_spc_synth_ctrl (.*);
   always #2.5 clock = ~clock;
   always begin
      repeat (6) @(posedge clock);
      reference_input_pin <= ~reference_input_pin;
   end
   // IF loop tick spacing and tick counts since the latest start
   always @(posedge clock) begin
      sen_q <= serial_enable_n;
      tun_q <= loop_tuning[2];
      gap <= loop_compare[2] ? 18'h1 : gap + 18'h1;
      if (loop_compare[2]) begin
         last_gap <= gap;
      end
      if ((serial_enable_n && !sen_q) || (loop_tuning[2] && !tun_q)) begin
         tune_ticks <= 18'h0;
         all_ticks <= 18'h0;
      end else if (loop_compare[2]) begin
         all_ticks <= all_ticks + 18'h1;
         tune_ticks <= tune_ticks + {17'h0, loop_tuning[2]};
      end
   end
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      i_spc_host_model.send(a, d);
   endtask
   task automatic wait_view(input int idx, input logic lvl);
      logic [5:0] v;
      for (int n = 0; n < 20000; n++) begin
         @(posedge clock);
         v = {loop_settled, loop_tuning};
         if (v[idx] === lvl) begin
            return;
         end
      end
      check("sequencer wait", 18'h0, 18'h1);
      final_report();
   endtask
   task automatic power_modes();
      wr(`SPC_ADDR_PWR, 18'h00003);
      check("pin low", {rf_section_on, if_section_on, ref_amp_on}, 18'h0);
      chip_powerdown_n_pin <= 1'b1;
      repeat (8) @(posedge clock);
      check("both enables", {rf_section_on, if_section_on, ref_amp_on}, 18'h7);
      wr(`SPC_ADDR_PWR, 18'h00001);
      check("rf enable", {rf_section_on, if_section_on, ref_amp_on}, 18'h5);
      wr(`SPC_ADDR_MAIN, 18'h00008);
      check("auto power", {rf_section_on, if_section_on, ref_amp_on}, 18'h7);
      wr(`SPC_ADDR_PWR, 18'h00000);
      wr(`SPC_ADDR_MAIN, 18'h00000);
      check("all off", {rf_section_on, if_section_on, ref_amp_on}, 18'h0);
      $display("power_modes done");
   endtask
   task automatic gain_codes();
      logic [17:0] base;
      wr(`SPC_ADDR_GAIN, 18'h00039);
      check("manual gains", {if_gain_code, rf2_gain_code, rf1_gain_code}, 18'h39);
      wr(`SPC_ADDR_MAIN, 18'h00004);
      for (int lvl = 0; lvl < 4; lvl++) begin
         for (int k = 0; k < 3; k++) begin
            base = 18'h02000 >> k;
            wr(`SPC_ADDR_N_RF1 + 4'(k), lvl == 0 ? base - 18'h1 : base << (lvl - 1));
         end
         check("auto gains", {if_gain_code, rf2_gain_code, rf1_gain_code}, {12'h0, {3{2'(lvl)}}});
      end
      $display("gain_codes done");
   endtask
   task automatic rf_path();
      wr(`SPC_ADDR_N_RF2, 18'd5000);
      check("rf2 by n", {17'h0, rf2_path_active}, 18'h1);
      wr(`SPC_ADDR_R_RF1, 18'd1);
      check("rf1 by r", {17'h0, rf2_path_active}, 18'h0);
      wr(`SPC_ADDR_R_RF2, 18'd1);
      wr(4'h9, 18'h3FFFF);
      check("reserved write", {17'h0, rf2_path_active}, 18'h1);
      $display("rf_path done");
   endtask
   task automatic tune_sequence();
      wr(`SPC_ADDR_R_IF, 18'd20);
      wr(`SPC_ADDR_MAIN, 18'h03828);
      check("if amp settings", {15'h0, if_output_divide, if_amp_low_bias}, 18'h5);
      wr(`SPC_ADDR_N_IF, 18'd3000);
      wait_view(2, 1'b0);
      check("tune ticks", tune_ticks, 18'd13);
      check("tick spacing", last_gap, 18'd240);
      wait_view(5, 1'b1);
      repeat (2) @(posedge clock);
      check("total ticks", all_ticks, 18'd38);
      check("warn low", {aux_output_pin, lock_warn_n}, 18'h0);
      if_near_limit <= 1'b1;
      repeat (4) @(posedge clock);
      check("warn at limit", {aux_output_pin, lock_warn_n}, 18'h3);
      if_near_limit <= 1'b0;
      wr(`SPC_ADDR_N_IF, 18'd3000);
      check("re-tune on warning", {16'h0, loop_tuning[2], lock_warn_n}, 18'h3);
      $display("tune_sequence done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      power_modes();
      gain_codes();
      rf_path();
      tune_sequence();
      final_report();
   end
endmodule // tb_spc_synth_ctrl
